// ==== logic/axis_status_pkg.sv ====
// package: offsets, field positions, command codes and carriers for the status readback bank
`default_nettype none
package axis_status_pkg;
  // register indices on the documented read port
  localparam logic [2:0] reg_error_finish = 3'h2;
  localparam logic [2:0] reg_paged_status = 3'h3;
  localparam logic [2:0] reg_pio_xy       = 3'h4;
  localparam logic [2:0] reg_pio_zu       = 3'h5;
  localparam logic [2:0] reg_data_low     = 3'h6;
  localparam logic [2:0] reg_data_high    = 3'h7;
  // field positions
  localparam int halt_lsb      = 0;
  localparam int enc_a_bit     = 3;
  localparam int enc_b_bit     = 4;
  localparam int in_pos_bit    = 5;
  localparam int fault_bit     = 6;
  localparam int plus_lim_bit  = 7;
  localparam int minus_lim_bit = 8;
  localparam int homing_lsb    = 9;
  localparam int page_bit      = 15;
  localparam int phase_lsb     = 4;
  localparam int jerk_lsb      = 7;
  localparam int timer_bit     = 10;
  localparam int split_bit     = 11;
  localparam int mc_err_bit    = 12;
  localparam int err_mc_bit    = 7;
  // command codes
  localparam logic [7:0] cmd_page_inputs = 8'h7a;
  localparam logic [7:0] cmd_page_motion = 8'h7b;
  localparam logic [7:0] cmd_nop         = 8'h1f;
  localparam logic [7:0] cmd_sync_en_lo  = 8'h81;
  localparam logic [7:0] cmd_sync_en_hi  = 8'h8f;
  localparam logic [7:0] cmd_sync_dis_lo = 8'h91;
  localparam logic [7:0] cmd_sync_dis_hi = 8'h9f;
  // reset values
  localparam logic [15:0] word_reset = 16'h0000;
  localparam logic        page_reset = 1'b0;
  localparam logic [3:0]  axis_reset = 4'h1;
  // profile phase and jerk phase codes from the drive engine
  typedef enum logic [1:0] {
    ph_idle = 2'h0, ph_accel = 2'h1, ph_const = 2'h2, ph_decel = 2'h3
  } phase_t;
  // per-axis pin and engine status carrier
  typedef struct packed {
    logic [2:0] halt;
    logic       enc_a;
    logic       enc_b;
    logic       in_pos;
    logic       fault;
    logic       plus_lim;
    logic       minus_lim;
    logic [5:0] homing_step;
    phase_t     speed_phase;
    phase_t     jerk_phase;
    logic       timer_run;
    logic       split_run;
    logic       mc_err_evt;
    logic [7:0] gp_in;
    logic [7:0] gp_out;
    logic [7:0] gp_dir_out;
  } axis_stat_t;
  // command write carrier
  typedef struct packed {
    logic       wr;
    logic [7:0] code;
    logic [3:0] axis;
  } cmd_t;
endpackage : axis_status_pkg
`default_nettype wire

// ==== logic/axis_status_readback_regs.sv ====
// paged per-axis status, pin readback and data-read word pair of the motion controller
// Notes on behaviour
// (R1) input bits read pin level, no inversion
// (R2) bits 2..0 show three halt input levels
// (R3) bits 3,4 encoder pins, swap setting ignored
// (R4) bit 5 in-position, bit 6 servo fault
// (R5) bits 7,8 limit pins, swap setting ignored
// (R6) bits 8..0 readable as general inputs
// (R7) bits 14..9 show homing step code
// (R8) bit 15 shows displayed page number
// (R9) motion bits 3..0 show enabled sync actions
// (R10) one of accel/constant/decel bits while driving
// (R11) s-curve jerk rising/flat/falling bits 7..9
// (R12) bit 10 set while timer runs
// (R13) bit 11 set while split pulse runs
// (R14) multichip error sets bit 12 and error bit 7
// (R15) xy readback: x low byte, y high
// (R16) pin bit shows input or driven level
// (R17) zu readback: z low byte, u high
// (R18) data-read loads low and high words
// (R19) data-read words are plain two's complement
// (R20) page commands select page, inputs after reset
// (R21) reads address axis of last command
// (R22) reads have no side effects
`default_nettype none
module axis_status_readback_regs (
  // clock and reset
  input  wire logic                              ref_clk,
  input  wire logic                              rst_b,
  // command write strobe from the command decoder
  input  wire axis_status_pkg::cmd_t             cmd,
  // per-axis status from pins and drive engine, x y z u
  input  wire axis_status_pkg::axis_stat_t [3:0] axis_stat,
  // data-read value and its load strobe
  input  wire logic                              data_load,
  input  wire logic [31:0]                       data_value,
  // error-status clear for the multichip error flags
  input  wire logic                              err_clear,
  // register read port
  input  wire logic [2:0]                        rd_addr,
  output logic [15:0]                            rd_data,
  // error flag seen by the error/finish status register
  output logic [3:0]                             mc_err_flag
);

  // ********************************************************
  // decode helpers
  // ********************************************************
  function automatic logic [1:0] axis_index(input logic [3:0] sel);
    logic [1:0] idx;
    idx = 2'd0;
    if (sel[1]) idx = 2'd1;
    if (sel[2]) idx = 2'd2;
    if (sel[3]) idx = 2'd3;
    return idx;
  endfunction : axis_index

  function automatic logic [2:0] one_hot_phase(input axis_status_pkg::phase_t ph);
    logic [2:0] v;
    v = 3'h0;
    case (ph)
      axis_status_pkg::ph_accel: v = 3'h1;
      axis_status_pkg::ph_const: v = 3'h2;
      axis_status_pkg::ph_decel: v = 3'h4;
      default:                   v = 3'h0;
    endcase
    return v;
  endfunction : one_hot_phase

  function automatic logic [7:0] pin_levels(input axis_status_pkg::axis_stat_t s);
    // output pins report what is driven, input pins what is sampled
    return (s.gp_out & s.gp_dir_out) | (s.gp_in & ~s.gp_dir_out); // R16
  endfunction : pin_levels

  // ********************************************************
  // control state: page, axis target, sync enables, data words
  // ********************************************************
  logic [3:0]  axis_sel_q, axis_sel_d;
  logic [3:0]  page_q, page_d;
  logic [3:0]  sync_en_q [4];
  logic [3:0]  sync_en_d [4];
  logic [3:0]  mc_err_q, mc_err_d;
  logic [15:0] data_low_q, data_low_d;
  logic [15:0] data_high_q, data_high_d;

  always_comb begin
    axis_sel_d  = axis_sel_q;
    page_d      = page_q;
    sync_en_d   = sync_en_q;
    mc_err_d    = mc_err_q;
    data_low_d  = data_low_q;
    data_high_d = data_high_q;
    if (cmd.wr && cmd.axis != 4'h0) begin
      axis_sel_d = cmd.axis; // R21
    end
    for (int a = 0; a < 4; a++) begin
      if (cmd.wr && cmd.axis[a]) begin
        if (cmd.code == axis_status_pkg::cmd_page_inputs) page_d[a] = 1'b0; // R20
        if (cmd.code == axis_status_pkg::cmd_page_motion) page_d[a] = 1'b1; // R20
        // low nibble of the code picks which actions change
        if (cmd.code >= axis_status_pkg::cmd_sync_en_lo &&
            cmd.code <= axis_status_pkg::cmd_sync_en_hi) begin
          sync_en_d[a] = sync_en_q[a] | cmd.code[3:0]; // R9
        end
        if (cmd.code >= axis_status_pkg::cmd_sync_dis_lo &&
            cmd.code <= axis_status_pkg::cmd_sync_dis_hi) begin
          sync_en_d[a] = sync_en_q[a] & ~cmd.code[3:0]; // R9
        end
      end
      // a new error outranks a clear in the same cycle
      if (err_clear) mc_err_d[a] = 1'b0;
      if (axis_stat[a].mc_err_evt) mc_err_d[a] = 1'b1; // R14
    end
    if (data_load) begin
      data_low_d  = data_value[15:0];  // R18 R19
      data_high_d = data_value[31:16]; // R18 R19
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      axis_sel_q  <= axis_status_pkg::axis_reset;
      page_q      <= {4{axis_status_pkg::page_reset}};
      sync_en_q   <= '{default: 4'h0};
      mc_err_q    <= 4'h0;
      data_low_q  <= axis_status_pkg::word_reset;
      data_high_q <= axis_status_pkg::word_reset;
    end else begin
      axis_sel_q  <= axis_sel_d;
      page_q      <= page_d;
      sync_en_q   <= sync_en_d;
      mc_err_q    <= mc_err_d;
      data_low_q  <= data_low_d;
      data_high_q <= data_high_d;
    end
  end

  // ********************************************************
  // per-axis page words
  // ********************************************************
  logic [15:0] inputs_word [4];
  logic [15:0] motion_word [4];

  for (genvar g = 0; g < 4; g++) begin : g_axis
    always_comb begin
      inputs_word[g] = 16'h0000;
      // raw pin levels, no polarity or swap applied
      inputs_word[g][axis_status_pkg::halt_lsb +: 3]     = axis_stat[g].halt;      // R1 R2 R6
      inputs_word[g][axis_status_pkg::enc_a_bit]         = axis_stat[g].enc_a;     // R3
      inputs_word[g][axis_status_pkg::enc_b_bit]         = axis_stat[g].enc_b;     // R3
      inputs_word[g][axis_status_pkg::in_pos_bit]        = axis_stat[g].in_pos;    // R4
      inputs_word[g][axis_status_pkg::fault_bit]         = axis_stat[g].fault;     // R4
      inputs_word[g][axis_status_pkg::plus_lim_bit]      = axis_stat[g].plus_lim;  // R5
      inputs_word[g][axis_status_pkg::minus_lim_bit]     = axis_stat[g].minus_lim; // R5
      inputs_word[g][axis_status_pkg::homing_lsb +: 6]   = axis_stat[g].homing_step; // R7
      inputs_word[g][axis_status_pkg::page_bit]          = 1'b0; // R8
      motion_word[g] = 16'h0000;
      motion_word[g][3:0]                                = sync_en_q[g]; // R9
      motion_word[g][axis_status_pkg::phase_lsb +: 3]    =
        one_hot_phase(axis_stat[g].speed_phase); // R10
      motion_word[g][axis_status_pkg::jerk_lsb +: 3]     =
        one_hot_phase(axis_stat[g].jerk_phase); // R11
      motion_word[g][axis_status_pkg::timer_bit]         = axis_stat[g].timer_run; // R12
      motion_word[g][axis_status_pkg::split_bit]         = axis_stat[g].split_run; // R13
      motion_word[g][axis_status_pkg::mc_err_bit]        = mc_err_q[g]; // R14
      motion_word[g][axis_status_pkg::page_bit]          = 1'b1; // R8
    end
  end

  // ********************************************************
  // read mux, registered; reads change no state
  // ********************************************************
  logic [15:0] rd_data_d;
  logic [1:0]  ax;

  always_comb begin
    ax        = axis_index(axis_sel_q); // R21
    rd_data_d = 16'h0000;
    case (rd_addr)
      axis_status_pkg::reg_paged_status:
        rd_data_d = page_q[ax] ? motion_word[ax] : inputs_word[ax]; // R8 R20
      axis_status_pkg::reg_error_finish:
        rd_data_d = 16'(mc_err_q[ax]) << axis_status_pkg::err_mc_bit; // R14
      axis_status_pkg::reg_pio_xy:
        rd_data_d = {pin_levels(axis_stat[1]), pin_levels(axis_stat[0])}; // R15
      axis_status_pkg::reg_pio_zu:
        rd_data_d = {pin_levels(axis_stat[3]), pin_levels(axis_stat[2])}; // R17
      axis_status_pkg::reg_data_low:  rd_data_d = data_low_q;  // R18
      axis_status_pkg::reg_data_high: rd_data_d = data_high_q; // R18
      default:                        rd_data_d = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data     <= axis_status_pkg::word_reset;
      mc_err_flag <= 4'h0;
    end else begin
      rd_data     <= rd_data_d; // R22
      mc_err_flag <= mc_err_d;  // R14
    end
  end

  // ********************************************************
  // checks
  // ********************************************************
  property p_page_after_reset;
    @(posedge ref_clk) $rose(rst_b) |-> page_q == 4'h0;
  endproperty
  a_page_after_reset: assert property (p_page_after_reset) // R20
    else $error("page not inputs after reset");

  property p_page_cmd;
    @(posedge ref_clk) disable iff (!rst_b)
      cmd.wr && cmd.axis[0] && cmd.code == axis_status_pkg::cmd_page_motion |=> page_q[0];
  endproperty
  a_page_cmd: assert property (p_page_cmd) // R20
    else $error("motion page command ignored");

  property p_page_bit;
    @(posedge ref_clk) disable iff (!rst_b)
      rd_addr == axis_status_pkg::reg_paged_status |=> rd_data[15] == $past(page_q[ax]);
  endproperty
  a_page_bit: assert property (p_page_bit) // R8
    else $error("page bit wrong");

  property p_halt_bits;
    @(posedge ref_clk) disable iff (!rst_b)
      rd_addr == axis_status_pkg::reg_paged_status && !page_q[ax]
      |=> rd_data[2:0] == $past(axis_stat[ax].halt);
  endproperty
  a_halt_bits: assert property (p_halt_bits) // R2
    else $error("halt bits mismatch");

  property p_phase_onehot;
    @(posedge ref_clk) disable iff (!rst_b)
      axis_stat[0].speed_phase != axis_status_pkg::ph_idle |-> $onehot(motion_word[0][6:4]);
  endproperty
  a_phase_onehot: assert property (p_phase_onehot) // R10
    else $error("phase bits not one-hot");

  property p_mc_err;
    @(posedge ref_clk) disable iff (!rst_b)
      axis_stat[0].mc_err_evt |=> mc_err_q[0] && mc_err_flag[0];
  endproperty
  a_mc_err: assert property (p_mc_err) // R14
    else $error("multichip error not flagged");

  property p_data_load;
    @(posedge ref_clk) disable iff (!rst_b)
      data_load |=> {data_high_q, data_low_q} == $past(data_value);
  endproperty
  a_data_load: assert property (p_data_load) // R18
    else $error("data words not loaded");

  property p_pio_xy;
    @(posedge ref_clk) disable iff (!rst_b)
      rd_addr == axis_status_pkg::reg_pio_xy
      |=> rd_data == $past({pin_levels(axis_stat[1]), pin_levels(axis_stat[0])});
  endproperty
  a_pio_xy: assert property (p_pio_xy) // R15
    else $error("xy readback wrong");

  property p_pio_zu;
    @(posedge ref_clk) disable iff (!rst_b)
      rd_addr == axis_status_pkg::reg_pio_zu
      |=> rd_data == $past({pin_levels(axis_stat[3]), pin_levels(axis_stat[2])});
  endproperty
  a_pio_zu: assert property (p_pio_zu) // R17
    else $error("zu readback wrong");

  property p_timer_split;
    @(posedge ref_clk) disable iff (!rst_b)
      rd_addr == axis_status_pkg::reg_paged_status && page_q[ax]
      |=> rd_data[axis_status_pkg::split_bit] == $past(axis_stat[ax].split_run) &&
          rd_data[axis_status_pkg::timer_bit] == $past(axis_stat[ax].timer_run);
  endproperty
  a_timer_split: assert property (p_timer_split) // R12 R13
    else $error("timer or split bit wrong");

  property p_jerk_onehot;
    @(posedge ref_clk) disable iff (!rst_b)
      axis_stat[0].jerk_phase != axis_status_pkg::ph_idle
      |-> $onehot(motion_word[0][axis_status_pkg::jerk_lsb +: 3]);
  endproperty
  a_jerk_onehot: assert property (p_jerk_onehot) // R11
    else $error("jerk bits not one-hot");

  property p_sync_en;
    @(posedge ref_clk) disable iff (!rst_b)
      cmd.wr && cmd.axis[0] && cmd.code >= axis_status_pkg::cmd_sync_en_lo &&
      cmd.code <= axis_status_pkg::cmd_sync_en_hi
      |=> (sync_en_q[0] & $past(cmd.code[3:0])) == $past(cmd.code[3:0]);
  endproperty
  a_sync_en: assert property (p_sync_en) // R9
    else $error("sync action not enabled");

  property p_sync_dis;
    @(posedge ref_clk) disable iff (!rst_b)
      cmd.wr && cmd.axis[0] && cmd.code >= axis_status_pkg::cmd_sync_dis_lo &&
      cmd.code <= axis_status_pkg::cmd_sync_dis_hi
      |=> (sync_en_q[0] & $past(cmd.code[3:0])) == 4'h0;
  endproperty
  a_sync_dis: assert property (p_sync_dis) // R9
    else $error("sync action not disabled");

  property p_axis_target;
    @(posedge ref_clk) disable iff (!rst_b)
      cmd.wr && cmd.axis != 4'h0 |=> axis_sel_q == $past(cmd.axis);
  endproperty
  a_axis_target: assert property (p_axis_target) // R21
    else $error("read target not moved");

  property p_err_set_wins;
    @(posedge ref_clk) disable iff (!rst_b)
      axis_stat[1].mc_err_evt && err_clear |=> mc_err_q[1] && mc_err_flag[1];
  endproperty
  a_err_set_wins: assert property (p_err_set_wins) // R14
    else $error("error lost to clear");

  property p_data_hold;
    @(posedge ref_clk) disable iff (!rst_b)
      !data_load |=> $stable({data_high_q, data_low_q});
  endproperty
  a_data_hold: assert property (p_data_hold) // R22
    else $error("data words changed without load");

endmodule : axis_status_readback_regs
`default_nettype wire

// ==== sim/host_reader.sv ====
// host side model: drives the read index and takes the registered answer
`default_nettype none
module host_reader (
  // clock
  input  wire logic        ref_clk,
  // read port
  output var  logic [2:0]  rd_addr,
  input  wire logic [15:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rd_addr = 3'h0;
  // two edges: one for the registered answer, one for command lag
  task automatic read(input logic [2:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    rd_addr <= a;
    repeat (2) @(posedge ref_clk);
    #1 d = rd_data;
  endtask : read
endmodule : host_reader
`default_nettype wire

// ==== sim/axis_status_readback_regs_test.sv ====
// random and corner-case bench for the status readback bank
`default_nettype none
module axis_status_readback_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                              ref_clk = 1'b0;
  logic                              rst_b = 1'b0;
  axis_status_pkg::cmd_t             cmd = '0;
  axis_status_pkg::axis_stat_t [3:0] st = '0;
  logic                              data_load = 1'b0;
  logic [31:0]                       data_value = '0;
  logic                              err_clear = 1'b0;
  logic [2:0]                        rd_addr;
  logic [15:0]                       rd_data;
  logic [3:0]                        mc_err_flag;
  logic [3:0]                        pg = '0;
  logic [3:0]                        err = '0;
  logic [3:0]                        sy [4] = '{default: '0};
  logic [1:0]                        tg = '0;
  logic [31:0]                       dv = '0;
  logic [15:0]                       v;
  logic [63:0]                       rv;
  int                                seed = 46150;
  int                                bad_count = 0;
  int                                n_tests = 0;

  always #5 ref_clk = ~ref_clk;

  axis_status_readback_regs dut (.ref_clk(ref_clk), .rst_b(rst_b), .cmd(cmd),
    .axis_stat(st), .data_load(data_load), .data_value(data_value),
    .err_clear(err_clear), .rd_addr(rd_addr), .rd_data(rd_data),
    .mc_err_flag(mc_err_flag));
  host_reader host (.ref_clk(ref_clk), .rd_addr(rd_addr), .rd_data(rd_data));

  // ************************************************
  // expectations
  // ************************************************
  function automatic logic [2:0] oh(input logic [1:0] p);
    return (p == 2'h0) ? 3'h0 : 3'h1 << (p - 2'h1);
  endfunction : oh
  function automatic logic [7:0] gp(input axis_status_pkg::axis_stat_t a);
    return (a.gp_in & ~a.gp_dir_out) | (a.gp_out & a.gp_dir_out);
  endfunction : gp
  function automatic logic [15:0] exp_reg(input logic [2:0] r);
    axis_status_pkg::axis_stat_t a;
    a = st[tg];
    case (r)
      3'h2: return {8'h00, err[tg], 7'h00};
      3'h3: if (pg[tg]) return {3'h4, err[tg], a.split_run, a.timer_run,
          oh(a.jerk_phase), oh(a.speed_phase), sy[tg]};
        else return {1'b0, a.homing_step, a.minus_lim, a.plus_lim, a.fault,
          a.in_pos, a.enc_b, a.enc_a, a.halt};
      3'h4: return {gp(st[1]), gp(st[0])};
      3'h5: return {gp(st[3]), gp(st[2])};
      3'h6: return dv[15:0];
      3'h7: return dv[31:16];
      default: return 16'h0000;
    endcase
  endfunction : exp_reg

  // ************************************************
  // tasks
  // ************************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic rd(input logic [2:0] r);
    host.read(r, v);
    check($sformatf("reg %0d", r), v, exp_reg(r));
  endtask : rd
  // last set axis bit becomes the read target
  task automatic send(input logic [7:0] c, input logic [3:0] ax);
    @(posedge ref_clk);
    cmd <= {1'b1, c, ax};
    @(posedge ref_clk);
    cmd.wr <= 1'b0;
    for (int i = 0; i < 4; i++) if (ax[i]) begin
      tg = i[1:0];
      if (c == 8'h7a || c == 8'h7b) pg[i] = c[0];
      if (c[7:4] == 4'h8) sy[i] = sy[i] | c[3:0];
      if (c[7:4] == 4'h9) sy[i] = sy[i] & ~c[3:0];
    end
  endtask : send
  task automatic mc(input logic [3:0] evt, input logic clr);
    @(posedge ref_clk);
    for (int i = 0; i < 4; i++) st[i].mc_err_evt <= evt[i];
    err_clear <= clr;
    @(posedge ref_clk);
    for (int i = 0; i < 4; i++) st[i].mc_err_evt <= 1'b0;
    err_clear <= 1'b0;
    err = (clr ? 4'h0 : err) | evt;
    // let the flag flops settle before anyone looks at them
    #1;
  endtask : mc
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  // ************************************************
  // sequence
  // ************************************************
  initial begin
    #200us;
    bad_count++;
    finish_test();
  end
  initial begin
    axis_status_pkg::axis_stat_t t;
    logic [3:0] m;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int r = 0; r < 8; r++) rd(r[2:0]);
    $display("reset view done");
    for (int k = 0; k < 40; k++) begin
      @(posedge ref_clk);
      for (int i = 0; i < 4; i++) begin
        rv = {$random(seed), $random(seed)};
        t = rv[45:0];
        t.mc_err_evt = 1'b0;
        st[i] <= t;
      end
      m = (k == 0) ? 4'h6 : 4'($random(seed));
      send({7'h3d, k[1]}, (m == 4'h0) ? 4'h8 : m);
      if (k[0]) send(axis_status_pkg::cmd_nop, 4'h1 << k[2:1]);
      rd(3'h3);
      rd(3'h4);
      rd(3'h5);
    end
    $display("status pages done");
    send(8'h7b, 4'hf);
    for (int c = 1; c < 32; c++) begin
      if (c == 16) continue;
      send({3'h4, c[4:0]} | 8'h80, 4'h1 << c[1:0]);
      rd(3'h3);
    end
    $display("sync actions done");
    for (int k = 0; k < 8; k++) begin
      @(posedge ref_clk);
      data_load <= 1'b1;
      data_value <= (k == 0) ? 32'hffff_fffb : (k == 1) ? 32'h8000_0000 : $random(seed);
      @(posedge ref_clk);
      data_load <= 1'b0;
      dv = data_value;
      rd(3'h6);
      rd(3'h7);
    end
    $display("data words done");
    send(axis_status_pkg::cmd_nop, 4'h4);
    mc(4'h4, 1'b0);
    rd(3'h3);
    rd(3'h2);
    check("mc flag", {12'h000, mc_err_flag}, {12'h000, err});
    mc(4'h2, 1'b1);
    rd(3'h2);
    check("mc flag", {12'h000, mc_err_flag}, {12'h000, err});
    mc(4'h0, 1'b1);
    check("mc flag", {12'h000, mc_err_flag}, {12'h000, err});
    $display("multichip error done");
    mc(4'h8, 1'b0);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    pg = '0;
    sy = '{default: '0};
    err = '0;
    dv = '0;
    tg = '0;
    for (int r = 2; r < 8; r++) rd(r[2:0]);
    check("mc flag", {12'h000, mc_err_flag}, {12'h000, err});
    $display("mid-run reset done");
    finish_test();
  end
endmodule : axis_status_readback_regs_test
`default_nettype wire
